// ### inc/fop_pkg.sv
// Shared constants for the offset-programming block of a deep 9-bit FIFO.
// Assumes both ends run on one clock; write and read edges are tick enables.
package fop_pkg;

	////////////////////////////////////////////////////////////////////////
	// Geometry
	localparam int           FIFO_DEPTH  = 16384;
	localparam int           WORD_W      = 9;
	localparam int           OFS_W       = 14;
	localparam int           SER_BITS    = 2 * OFS_W;
	localparam int           SER_IDX_W   = 5;

	////////////////////////////////////////////////////////////////////////
	// Offset defaults, chosen by the load-select level at master reset
	localparam logic [13:0]  OFS_DEF_PAR = 14'h007F;
	localparam logic [13:0]  OFS_DEF_SER = 14'h03FF;

	////////////////////////////////////////////////////////////////////////
	// Offset register pointer positions
	localparam logic [1:0]   PTR_E_LO    = 2'h0;
	localparam logic [1:0]   PTR_E_HI    = 2'h1;
	localparam logic [1:0]   PTR_F_LO    = 2'h2;
	localparam logic [1:0]   PTR_F_HI    = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// Controller register map and field layout
	localparam logic [3:0]   ADDR_CMD    = 4'h0;
	localparam logic [3:0]   ADDR_STAT   = 4'h4;
	localparam logic [3:0]   ADDR_RDATA  = 4'h8;
	localparam int           CMD_POS     = 9;
	localparam int           TICK_DIV_DEF = 4;

	typedef enum logic [2:0]
	{
		CMD_NOP,
		CMD_MEMWR,
		CMD_MEMRD,
		CMD_OFSWR,
		CMD_OFSRD,
		CMD_SERBIT,
		CMD_MRST,
		CMD_PRST
	} fop_cmd_t;

endpackage : fop_pkg

// ### inc/fop_link_if.sv
// Pin-level link between the FIFO offset logic and its controller.
// Assumes one shared clock; the controller owns the tick enables.
`timescale 1ns/1ps
interface fop_link_if
	import fop_pkg::*;
();
	logic              offset_program_select_n;
	logic              write_enable_n;
	logic              read_enable_n;
	logic              serial_offset_enable_n;
	logic              serialIn;
	logic [WORD_W-1:0] data_inputs;
	logic              wclkTick;
	logic              rclkTick;
	logic              master_reset_n;
	logic              partial_reset_n;
	logic [WORD_W-1:0] data_outputs;
	logic              output_ready_n;
	logic              input_ready_n;
	logic              half_full_flag_n;
	logic              almost_full_flag_n;
	logic              almost_empty_flag_n;

	modport device
	(
		input  offset_program_select_n, write_enable_n, read_enable_n, serial_offset_enable_n,
		input  serialIn, data_inputs, wclkTick, rclkTick, master_reset_n, partial_reset_n,
		output data_outputs, output_ready_n, input_ready_n, half_full_flag_n,
		output almost_full_flag_n, almost_empty_flag_n
	);

	modport controller
	(
		output offset_program_select_n, write_enable_n, read_enable_n, serial_offset_enable_n,
		output serialIn, data_inputs, wclkTick, rclkTick, master_reset_n, partial_reset_n,
		input  data_outputs, output_ready_n, input_ready_n, half_full_flag_n,
		input  almost_full_flag_n, almost_empty_flag_n
	);
endinterface : fop_link_if

// ### hdl/fop_device.sv
// FIFO end: fill level, fall-through flags and the four offset registers.
// Assumes the controller shares ref_clk and marks write/read edges by ticks.
// Function
// (R1) Fall-through half, almost-full, input-ready, output-ready thresholds
// (R2) Empty offset defaults; almost-empty low through n+1
// (R3) Full offset defaults; almost-full against capacity minus m
// (R4) Load-select low, write low: parallel offset write
// (R5) Load-select low, read low: parallel offset read
// (R6) Serial enable low: one bit per write edge
// (R7) Programming method fixed only at master reset
// (R8) Serial bits run empty LSB to full MSB
// (R9) Full serial set before flags; no selective write
// (R10) Serial enable high blocks serial shifting
// (R11) Serial load pauses and resumes at next bit
// (R12) Flags valid two edges after load completes
// (R13) No serial read-back path
// (R14) Write pointer cycles four registers, then wraps
// (R15) Independent write and read offset pointers
// (R16) Master reset clears pointers, partial keeps them
// (R17) Parallel write pauses, resumes at next register
// (R18) Flag invalid until its offset word written
// (R19) Read pointer cycles four registers, then wraps
// (R20) Read-back pauses, resumes where it left
// (R21) Offset read overwrites the output word
// (R22) Read-back works in every method and mode
// (R23) Load-select level at master reset picks method, defaults
// (R24) Load-select high: memory write/read, else no-op
`timescale 1ns/1ps
module fop_device
	import fop_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
)(
	input  wire logic              ref_clk,
	input  wire logic              srst,
	fop_link_if.device             link,
	output      logic [15:0]       fillLevel,
	output      logic              serialMode
);

	localparam int              CNT_W = 16;
	localparam logic [CNT_W-1:0] CAP  = CNT_W'(DEPTH + 1);
	localparam logic [CNT_W-1:0] HALF = CNT_W'(DEPTH / 2 + 2);

	////////////////////////////////////////////////////////////////////////
	// Register part selection, shared by write and read paths
	function automatic logic [WORD_W-1:0] readPart(input logic [SER_BITS-1:0] v, input logic [1:0] p);
		logic [OFS_W-1:0] o;
		o = p[1] ? v[SER_BITS-1:OFS_W] : v[OFS_W-1:0];
		readPart = p[0] ? WORD_W'(o[OFS_W-1:WORD_W]) : o[WORD_W-1:0];
	endfunction : readPart

	function automatic logic [SER_BITS-1:0] writePart(input logic [SER_BITS-1:0] v, input logic [1:0] p,
		input logic [WORD_W-1:0] d);
		logic [OFS_W-1:0]    o;
		logic [SER_BITS-1:0] r;
		r = v;
		o = p[1] ? v[SER_BITS-1:OFS_W] : v[OFS_W-1:0];
		if (p[0])
		begin
			o[OFS_W-1:WORD_W] = d[OFS_W-WORD_W-1:0];
		end
		else
		begin
			o[WORD_W-1:0] = d;
		end
		if (p[1])
		begin
			r[SER_BITS-1:OFS_W] = o;
		end
		else
		begin
			r[OFS_W-1:0] = o;
		end
		writePart = r;
	endfunction : writePart

	////////////////////////////////////////////////////////////////////////
	// State
	logic [CNT_W-1:0]     count;
	logic [SER_BITS-1:0]  ofsAll;
	logic [SER_IDX_W-1:0] serIdx;
	logic [1:0]           wrPtr;
	logic [1:0]           rdPtr;
	logic [OFS_W-1:0]     aeAct;
	logic [OFS_W-1:0]     afAct;
	logic [1:0]           afPipe;
	logic [1:0]           aePipe;
	logic                 aeReq;

	////////////////////////////////////////////////////////////////////////
	// Control decode
	wire              ldLow      = ~link.offset_program_select_n;
	wire              wrLow      = ~link.write_enable_n;
	wire              rdLow      = ~link.read_enable_n;
	wire              senLow     = ~link.serial_offset_enable_n;
	wire              masterRst  = srst | ~link.master_reset_n;
	wire              anyRst     = masterRst | ~link.partial_reset_n;
	wire [OFS_W-1:0]  strapOfs   = link.offset_program_select_n ? OFS_DEF_SER : OFS_DEF_PAR; // [R23]
	wire [OFS_W-1:0]  rstOfs     = srst ? OFS_DEF_PAR : strapOfs;                            // [R2] [R3]
	wire              parWr      = ldLow & wrLow & ~rdLow & ~senLow & ~serialMode & link.wclkTick; // [R4] [R17]
	// Serial enable high or load-select high leaves the bit index parked
	wire              serWr      = ldLow & ~wrLow & ~rdLow & senLow & serialMode & link.wclkTick;  // [R6] [R10] [R11]
	// Read-back is open in either method; no serial read decode exists
	wire              parRd      = ldLow & ~wrLow & rdLow & ~senLow & link.rclkTick; // [R5] [R13] [R22]
	wire              memWr      = ~ldLow & wrLow & link.wclkTick & (count != CAP);  // [R24]
	wire              memRd      = ~ldLow & rdLow & link.rclkTick & (count != '0);   // [R24]
	wire              serLast    = serWr & (serIdx == SER_IDX_W'(SER_BITS - 1));
	wire              aeDone     = serLast | (parWr & (wrPtr == PTR_E_HI));          // [R9] [R18]
	wire              afDone     = serLast | (parWr & (wrPtr == PTR_F_HI));          // [R9] [R18]
	wire [CNT_W-1:0]  next_count = anyRst ? '0 : count + CNT_W'(memWr) - CNT_W'(memRd);
	wire [SER_BITS-1:0] next_ofsAll = parWr ? writePart(ofsAll, wrPtr, link.data_inputs) : ofsAll;
	wire [CNT_W-1:0]  aeLimit    = CNT_W'(aeAct) + CNT_W'(1);
	wire [CNT_W-1:0]  afLimit    = CAP - CNT_W'(afAct);

	////////////////////////////////////////////////////////////////////////
	// Fill level
	always_ff @(posedge ref_clk)
	begin
		count <= next_count;
	end

	////////////////////////////////////////////////////////////////////////
	// Method strap; only master reset may change it
	always_ff @(posedge ref_clk)
	begin
		if (masterRst)
		begin
			serialMode <= ~srst & link.offset_program_select_n; // [R7] [R23]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Offset registers
	always_ff @(posedge ref_clk)
	begin
		if (masterRst)
		begin
			ofsAll <= {rstOfs, rstOfs};
		end
		else if (serWr)
		begin
			ofsAll[serIdx] <= link.serialIn; // [R8]
		end
		else
		begin
			ofsAll <= next_ofsAll;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pointers; partial reset deliberately leaves them alone
	always_ff @(posedge ref_clk)
	begin
		if (masterRst)
		begin
			wrPtr  <= PTR_E_LO; // [R16]
			rdPtr  <= PTR_E_LO; // [R16]
			serIdx <= '0;
		end
		else
		begin
			if (parWr)
			begin
				wrPtr <= wrPtr + 2'h1; // [R14] [R15]
			end
			if (parRd)
			begin
				rdPtr <= rdPtr + 2'h1; // [R19] [R15] [R20]
			end
			if (serWr)
			begin
				serIdx <= serLast ? '0 : serIdx + SER_IDX_W'(1); // [R11]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Active thresholds follow a completed load two edges later
	always_ff @(posedge ref_clk)
	begin
		if (masterRst)
		begin
			aeAct  <= rstOfs;
			afAct  <= rstOfs;
			afPipe <= 2'h0;
			aePipe <= 2'h0;
			aeReq  <= 1'b0;
		end
		else
		begin
			if (link.wclkTick)
			begin
				afPipe <= {afPipe[0], afDone}; // [R12]
				if (afPipe[1])
				begin
					afAct <= ofsAll[SER_BITS-1:OFS_W];
				end
			end
			// A load finishing on a write tick waits for the read side
			if (aeDone)
			begin
				aeReq <= 1'b1;
			end
			else if (link.rclkTick)
			begin
				aeReq <= 1'b0;
			end
			if (link.rclkTick)
			begin
				aePipe <= {aePipe[0], aeReq | aeDone}; // [R12]
				if (aePipe[1])
				begin
					aeAct <= ofsAll[OFS_W-1:0];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered flags and output word
	always_ff @(posedge ref_clk)
	begin
		fillLevel                <= next_count;
		link.output_ready_n      <= (next_count == '0);        // [R1]
		link.input_ready_n       <= (next_count == CAP);       // [R1]
		link.half_full_flag_n    <= (next_count < HALF);       // [R1]
		link.almost_full_flag_n  <= (next_count < afLimit);    // [R1] [R3]
		link.almost_empty_flag_n <= (next_count > aeLimit);    // [R2]
	end

	// No memory array here: a memory read leaves the output word as it was
	always_ff @(posedge ref_clk)
	begin
		if (anyRst)
		begin
			link.data_outputs <= '0;
		end
		else if (parRd)
		begin
			link.data_outputs <= readPart(ofsAll, rdPtr); // [R21]
		end
	end

endmodule : fop_device

// ### hdl/fop_controller.sv
// Controller end: register port in, pin sequences and tick enables out.
// Assumes the FIFO end shares ref_clk and samples pins on tick cycles.
`timescale 1ns/1ps
module fop_controller
	import fop_pkg::*;
#(
	parameter int TICK_DIV = TICK_DIV_DEF
)(
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic [3:0]  busAddr,
	input  wire logic [31:0] busWdata,
	input  wire logic        busWr,
	input  wire logic        busRd,
	output      logic [31:0] busRdata,
	fop_link_if.controller   link
);

	typedef enum logic [1:0] {ST_IDLE, ST_DRIVE, ST_CAPT} fop_state_t;

	fop_state_t        state;
	logic [7:0]        divCnt;
	logic [WORD_W-1:0] lastData;

	////////////////////////////////////////////////////////////////////////
	// Decode
	wire        tickNow = (divCnt == 8'(TICK_DIV - 1));
	wire        accept  = busWr & (busAddr == ADDR_CMD) & (state == ST_IDLE);
	wire [2:0]  newCmd  = busWdata[CMD_POS+2:CMD_POS];
	wire        isOfs   = (newCmd == CMD_OFSWR) | (newCmd == CMD_OFSRD) | (newCmd == CMD_SERBIT);
	wire        isMrst  = (newCmd == CMD_MRST);
	wire        drvLd   = isMrst ? ~busWdata[0] : isOfs;
	wire        drvWen  = (newCmd == CMD_MEMWR) | (newCmd == CMD_OFSWR);
	wire        drvRen  = (newCmd == CMD_MEMRD) | (newCmd == CMD_OFSRD);
	wire [5:0]  status  = {link.almost_empty_flag_n, link.almost_full_flag_n, link.half_full_flag_n,
		link.input_ready_n, link.output_ready_n, state != ST_IDLE};
	wire [31:0] rdMux   = (busAddr == ADDR_STAT)  ? 32'(status) :
	                      (busAddr == ADDR_RDATA) ? 32'(lastData) : 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////
	// Tick divider; both edge enables share it
	always_ff @(posedge ref_clk)
	begin
		divCnt        <= (srst | tickNow) ? 8'h00 : divCnt + 8'h01;
		link.wclkTick <= ~srst & tickNow;
		link.rclkTick <= ~srst & tickNow;
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer: one operation at a time keeps offset reads and writes apart
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			state <= ST_IDLE;
		end
		else
		begin
			unique case (state)
				ST_IDLE:
				begin
					if (accept)
					begin
						state <= ST_DRIVE; // [R15]
					end
				end
				ST_DRIVE:
				begin
					if (link.wclkTick)
					begin
						state <= ST_CAPT;
					end
				end
				ST_CAPT:
				begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Idle pins are all high: load-select high pauses any sequence
	always_ff @(posedge ref_clk)
	begin
		if (srst | ((state == ST_DRIVE) & link.wclkTick))
		begin
			link.offset_program_select_n <= 1'b1; // [R11] [R17] [R20]
			link.write_enable_n          <= 1'b1;
			link.read_enable_n           <= 1'b1;
			link.serial_offset_enable_n  <= 1'b1;
			link.master_reset_n          <= 1'b1;
			link.partial_reset_n         <= 1'b1;
		end
		else if (accept)
		begin
			link.offset_program_select_n <= ~drvLd; // [R23]
			link.write_enable_n          <= ~drvWen;
			link.read_enable_n           <= ~drvRen;
			link.serial_offset_enable_n  <= ~(newCmd == CMD_SERBIT);
			link.master_reset_n          <= ~isMrst;
			link.partial_reset_n         <= ~(newCmd == CMD_PRST);
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			link.data_inputs <= '0;
			link.serialIn    <= 1'b0;
			lastData         <= '0;
			busRdata         <= 32'h0000_0000;
		end
		else
		begin
			if (accept)
			begin
				link.data_inputs <= busWdata[WORD_W-1:0];
				link.serialIn    <= busWdata[0];
			end
			if (state == ST_CAPT)
			begin
				lastData <= link.data_outputs;
			end
			busRdata <= busRd ? rdMux : 32'h0000_0000;
		end
	end

endmodule : fop_controller

// ### test/fop_link_assertions.sv
// Link checker for the FIFO offset end and its controller.
// Assumes one clock; the bench places it beside the link.
`timescale 1ns/1ps
module fop_link_assertions
	import fop_pkg::*;
(
	input wire logic              ref_clk,
	input wire logic              srst,
	input wire logic              offset_program_select_n,
	input wire logic              write_enable_n,
	input wire logic              read_enable_n,
	input wire logic              serial_offset_enable_n,
	input wire logic              wclkTick,
	input wire logic              rclkTick,
	input wire logic              master_reset_n,
	input wire logic              partial_reset_n,
	input wire logic [WORD_W-1:0] data_outputs,
	input wire logic              output_ready_n,
	input wire logic              input_ready_n,
	input wire logic              half_full_flag_n,
	input wire logic              almost_full_flag_n,
	input wire logic              almost_empty_flag_n
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	// Resets win over every pin combination, so they gate each decode
	wire logic live   = master_reset_n && partial_reset_n;
	wire logic mem    = live && offset_program_select_n;
	wire logic ofs    = live && !offset_program_select_n;
	wire logic memWr  = mem && wclkTick && !write_enable_n;
	wire logic memRd  = mem && rclkTick && !read_enable_n && !output_ready_n;
	wire logic parWr  = ofs && wclkTick && !write_enable_n && read_enable_n && serial_offset_enable_n;
	wire logic parRd  = ofs && rclkTick && write_enable_n && !read_enable_n && serial_offset_enable_n;
	wire logic serBit = ofs && wclkTick && write_enable_n && read_enable_n && !serial_offset_enable_n;
	////////////////////////////////////////
	property p_or_wr; memWr |-> ##[1:2] !output_ready_n; endproperty
	a_or_wr: assert property (p_or_wr) else $error("no word after write");
	property p_ir_rd; memRd |=> !input_ready_n; endproperty
	a_ir_rd: assert property (p_ir_rd) else $error("still full after read");
	property p_full; input_ready_n |-> !half_full_flag_n && !almost_full_flag_n && !output_ready_n; endproperty
	a_full: assert property (p_full) else $error("full flags disagree");
	property p_empty; output_ready_n |-> !almost_empty_flag_n && half_full_flag_n && !input_ready_n; endproperty
	a_empty: assert property (p_empty) else $error("empty flags disagree");
	property p_mrst; !master_reset_n |=> output_ready_n && almost_full_flag_n && !almost_empty_flag_n
		&& data_outputs == '0; endproperty
	a_mrst: assert property (p_mrst) else $error("master reset state wrong");
	property p_prst; !partial_reset_n |=> output_ready_n && !input_ready_n && data_outputs == '0; endproperty
	a_prst: assert property (p_prst) else $error("partial reset state wrong");
	property p_ser; serBit |=> $stable(data_outputs) && $stable(output_ready_n); endproperty
	a_ser: assert property (p_ser) else $error("serial bit moved outputs");
	property p_pwr; parWr |=> $stable(data_outputs) && $stable(input_ready_n); endproperty
	a_pwr: assert property (p_pwr) else $error("offset write hit memory");
	property p_prd; parRd |=> $stable(output_ready_n) && $stable(input_ready_n); endproperty
	a_prd: assert property (p_prd) else $error("offset read hit memory");
endmodule : fop_link_assertions

// ### test/fifo_offset_flag_programming_tb.sv
// Bench: controller and FIFO end on one link, driven from the register port
// and compared with an integer model. Assumes one 100 MHz clock.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module fifo_offset_flag_programming_tb
	import fop_pkg::*;
;
	// Small depth keeps fills short; offsets drawn below 200 stay under it, the serial default and the last random writes may not
	localparam int DEP = 256;
	logic        ref_clk;
	logic        srst;
	logic [3:0]  busAddr;
	logic [31:0] busWdata;
	logic        busWr;
	logic        busRd;
	logic [31:0] busRdata;
	logic [31:0] rd;
	logic [15:0] fillLevel;
	logic        serialMode;
	logic        ser;
	logic [13:0] eReg, fReg, eAct, fAct;
	int          n_fail, checks_done, count, wrPtr, rdPtr, serIdx;

	fop_link_if link();
	fop_device #(.DEPTH(DEP)) i_fop_device (.ref_clk(ref_clk), .srst(srst), .link(link),
		.fillLevel(fillLevel), .serialMode(serialMode));
	fop_controller #(.TICK_DIV(2)) i_fop_controller (.ref_clk(ref_clk), .srst(srst), .busAddr(busAddr),
		.busWdata(busWdata), .busWr(busWr), .busRd(busRd), .busRdata(busRdata), .link(link));
	fop_link_assertions i_fop_link_assertions (.ref_clk(ref_clk), .srst(srst),
		.offset_program_select_n(link.offset_program_select_n), .write_enable_n(link.write_enable_n),
		.read_enable_n(link.read_enable_n), .serial_offset_enable_n(link.serial_offset_enable_n),
		.wclkTick(link.wclkTick), .rclkTick(link.rclkTick), .master_reset_n(link.master_reset_n),
		.partial_reset_n(link.partial_reset_n), .data_outputs(link.data_outputs),
		.output_ready_n(link.output_ready_n), .input_ready_n(link.input_ready_n),
		.half_full_flag_n(link.half_full_flag_n), .almost_full_flag_n(link.almost_full_flag_n),
		.almost_empty_flag_n(link.almost_empty_flag_n));
	////////////////////////////////////////
	task automatic end_of_test();
		$display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test

	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		busWr <= wr;
		busRd <= !wr;
		busAddr <= a;
		busWdata <= d;
		@(posedge ref_clk);
		busWr <= 1'b0;
		busRd <= 1'b0;
		#1 rd = busRdata;
	endtask : bus

	task automatic cmd(input fop_cmd_t c, input logic [8:0] d);
		int i;
		bus(1'b1, ADDR_CMD, {20'h0, c, d});
		repeat (2) @(posedge ref_clk);
		rd = '1;
		for (i = 0; i < 40 && rd[0] !== 1'b0; i++)
			bus(1'b0, ADDR_STAT, 32'h0);
		if (rd[0] !== 1'b0)
		begin
			n_fail++;
			end_of_test();
		end
	endtask : cmd

	function automatic logic [8:0] part(input int p);
		logic [13:0] v;
		v = p < 2 ? eReg : fReg;
		return p % 2 ? {4'h0, v[13:9]} : v[8:0];
	endfunction : part

	task automatic set_model(input logic s);
		ser = s;
		count = 0;
		wrPtr = 0;
		rdPtr = 0;
		serIdx = 0;
		eReg = s ? OFS_DEF_SER : OFS_DEF_PAR;
		fReg = eReg;
		eAct = eReg;
		fAct = eReg;
	endtask : set_model

	task automatic mrst(input logic s);
		cmd(CMD_MRST, {8'h00, s});
		set_model(s);
		`CHK(serialMode, s)
	endtask : mrst

	task automatic ofs_wr(input logic [8:0] d);
		cmd(CMD_OFSWR, d);
		if (!ser)
		begin
			if (wrPtr == 0) eReg[8:0] = d;
			if (wrPtr == 1) eReg[13:9] = d[4:0];
			if (wrPtr == 2) fReg[8:0] = d;
			if (wrPtr == 3) fReg[13:9] = d[4:0];
			if (wrPtr == 1) eAct = eReg;
			if (wrPtr == 3) fAct = fReg;
			wrPtr = (wrPtr + 1) % 4;
		end
	endtask : ofs_wr

	task automatic ofs_rd();
		cmd(CMD_OFSRD, 9'h000);
		bus(1'b0, ADDR_RDATA, 32'h0);
		`CHK(rd[8:0], part(rdPtr))
		rdPtr = (rdPtr + 1) % 4;
	endtask : ofs_rd

	task automatic ser_bit(input logic b);
		cmd(CMD_SERBIT, {8'h00, b});
		if (ser)
		begin
			if (serIdx < OFS_W) eReg[serIdx] = b;
			else fReg[serIdx - OFS_W] = b;
			serIdx = (serIdx + 1) % SER_BITS;
			if (serIdx == 0) eAct = eReg;
			if (serIdx == 0) fAct = fReg;
		end
	endtask : ser_bit

	task automatic mem_op(input logic wr);
		logic [4:0] x;
		cmd(wr ? CMD_MEMWR : CMD_MEMRD, 9'($urandom));
		count = wr ? count + (count <= DEP) : count - (count > 0);
		bus(1'b0, ADDR_STAT, 32'h0);
		x = {count > eAct + 1, count < DEP + 1 - fAct, count < DEP / 2 + 2, count > DEP, count == 0};
		`CHK(rd[5:1], x)
		`CHK(fillLevel, 16'(count))
	endtask : mem_op

	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	initial
	begin
		int j;
		int k;
		logic [27:0] sv;
		srst = 1'b1;
		busAddr = 4'h0;
		busWdata = 32'h0;
		busWr = 1'b0;
		busRd = 1'b0;
		n_fail = 0;
		checks_done = 0;
		void'($urandom(32'hA637));
		set_model(1'b0);
		repeat (16) @(posedge ref_clk);
		srst <= 1'b0;
		mem_op(1'b0);
		`CHK(serialMode, 1'b0)
		repeat (5) ofs_rd();
		$display("test defaults done");
		ofs_wr(9'($urandom % 200));
		ofs_wr(9'h000);
		mem_op(1'b1);
		ofs_wr(9'($urandom % 200));
		ofs_wr(9'h000);
		repeat (4) ofs_rd();
		cmd(CMD_PRST, 9'h000);
		count = 0;
		ofs_wr(9'($urandom % 200));
		repeat (4) ofs_rd();
		repeat (DEP + 2) mem_op(1'b1);
		repeat (DEP + 2) mem_op(1'b0);
		$display("test parallel done");
		mrst(1'b1);
		ofs_wr(9'h055);
		repeat (4) ofs_rd();
		// Second load is split by a memory write while the first set is live
		for (j = 0; j < 2; j++)
		begin
			sv = {14'($urandom % 200), 14'($urandom % 200)};
			for (k = 0; k < SER_BITS; k++)
			begin
				if (j == 1 && k == 10) mem_op(1'b1);
				ser_bit(sv[k]);
			end
		end
		// Partial reset must keep the serial method and the loaded offsets
		cmd(CMD_PRST, 9'h000);
		count = 0;
		`CHK(serialMode, 1'b1)
		repeat (4) ofs_rd();
		repeat (DEP + 2) mem_op(1'b1);
		repeat (DEP + 2) mem_op(1'b0);
		$display("test serial done");
		mrst(1'b0);
		ser_bit(1'b1);
		cmd(CMD_NOP, 9'h1FF);
		// A random empty-offset high part reaches bits that zero-valued writes never exercise
		ofs_wr(9'($urandom));
		ofs_wr(9'($urandom));
		repeat (4) ofs_rd();
		$display("test method done");
		end_of_test();
	end
endmodule : fifo_offset_flag_programming_tb
